// File: verilog/dagp_pkg.sv
// Package for the data address generator pair: mode register layout, widths and register port map
package dagp_pkg;
    localparam int ADDR_W = 32;
    localparam int RSEL_W = 4;
    localparam int NREG = 8;
    // Mode-control register fields
    localparam int WRAP_MODE_ENABLE_BIT = 24;
    localparam int BROADCAST_GEN1_PTR1_BIT = 23;
    localparam int BROADCAST_GEN2_PTR9_BIT = 22;
    localparam int DUAL_ELEMENT_ENABLE_BIT = 21;
    localparam int ALT_BANK_GEN2_LOW_BIT = 6;
    localparam int ALT_BANK_GEN2_HIGH_BIT = 5;
    localparam int ALT_BANK_GEN1_LOW_BIT = 4;
    localparam int ALT_BANK_GEN1_HIGH_BIT = 3;
    localparam int BITREV_GEN1_PTR0_BIT = 1;
    localparam int BITREV_GEN2_PTR8_BIT = 0;
    localparam logic [31:0] CORE_MODE_CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] CORE_MODE_CONTROL_MASK = 32'h01E0_007B;
    // Register port address map: [7:6] file, [5] generator, [4] bank, [3] special in file 3, [2:0] entry
    // Specials sit where bit 3 is set, so the base file keeps every one of its entries
    localparam logic [7:0] CORE_MODE_CONTROL_ADDR = 8'hF8;
    localparam logic [7:0] STICKY_STATUS_ADDR = 8'hF9;
    localparam logic [1:0] FILE_INDEX = 2'h0;
    localparam logic [1:0] FILE_MODIFY = 2'h1;
    localparam logic [1:0] FILE_LENGTH = 2'h2;
    localparam logic [1:0] FILE_BASE = 2'h3;
    localparam logic [31:0] STICKY_OVF_GEN1_BIT_POS = 32'h0;
    localparam logic [31:0] STICKY_OVF_GEN2_BIT_POS = 32'h1;
    // Operation codes from instruction decode
    typedef enum logic [1:0] {
        DAGP_OP_NONE,
        DAGP_OP_POST,
        DAGP_OP_PRE,
        DAGP_OP_MODIFY
    } dagp_op_t;
endpackage

// File: verilog/dagp_gen.sv
// One address generator: banked index, modify, length and base registers plus address arithmetic
`timescale 1ns/100ps
`default_nettype none
module dagp_gen #(
    parameter bit SECOND = 1'b0
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [1:0] bank_sel,
    input wire logic wrap_en,
    input wire logic bitrev_en,
    input wire dagp_pkg::dagp_op_t op,
    input wire logic [2:0] op_ireg,
    input wire logic [2:0] op_mreg,
    input wire logic op_use_imm,
    input wire logic [31:0] op_imm,
    input wire logic wr_en,
    input wire logic [1:0] wr_file,
    input wire logic wr_bank,
    input wire logic [2:0] wr_idx,
    input wire logic [31:0] wr_data,
    input wire logic [1:0] rd_file,
    input wire logic rd_bank,
    input wire logic [2:0] rd_idx,
    output logic [31:0] rd_data,
    output logic [31:0] addr,
    output logic addr_valid,
    output logic overflow
);
    // ------------------------------------------------------------
    // Banked register files: [bank][entry]
    // ------------------------------------------------------------
    logic [31:0] ireg [2][8];
    logic [31:0] mreg [2][8];
    logic [31:0] lreg [2][8];
    logic [31:0] breg [2][8];

    // Entries 0-3 follow bank_sel[0], entries 4-7 bank_sel[1]
    wire logic ib = bank_sel[op_ireg[2]];
    wire logic mb = bank_sel[op_mreg[2]];
    wire logic [31:0] cur_i = ireg[ib][op_ireg];
    wire logic [31:0] cur_l = lreg[ib][op_ireg];
    wire logic [31:0] cur_b = breg[ib][op_ireg];
    wire logic [31:0] step = op_use_imm ? op_imm : mreg[mb][op_mreg];
    wire logic [31:0] sum = cur_i + step;
    wire logic [31:0] end_addr = cur_b + cur_l;
    wire logic circ = wrap_en && (cur_l != 32'h0);
    // Positive step past end subtracts length, negative step below base adds it
    wire logic past_end = circ && !step[31] && (sum >= end_addr);
    wire logic below_base = circ && step[31] && (sum < cur_b);
    wire logic [31:0] next_i = past_end ? sum - cur_l : (below_base ? sum + cur_l : sum);
    wire logic updates = (op == dagp_pkg::DAGP_OP_POST) || (op == dagp_pkg::DAGP_OP_MODIFY);
    wire logic [31:0] raw_addr = (op == dagp_pkg::DAGP_OP_PRE) ? sum : cur_i;
    wire logic rev_here = bitrev_en && (op_ireg == 3'd0);
    wire logic is_access = (op == dagp_pkg::DAGP_OP_POST) || (op == dagp_pkg::DAGP_OP_PRE);
    wire logic [31:0] rd_mux [4];
    logic [31:0] rev_addr;

    assign rd_mux[0] = ireg[rd_bank][rd_idx];
    assign rd_mux[1] = mreg[rd_bank][rd_idx];
    assign rd_mux[2] = lreg[rd_bank][rd_idx];
    assign rd_mux[3] = breg[rd_bank][rd_idx];
    assign rd_data = rd_mux[rd_file];

    // ------------------------------------------------------------
    // Bit reversal of the driven address only
    // ------------------------------------------------------------
    for (genvar k = 0; k < 32; k++) begin : g_rev
        assign rev_addr[k] = raw_addr[31 - k];
    end

    // ------------------------------------------------------------
    // Register update; only the selected bank can change
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int b = 0; b < 2; b++) begin
                for (int e = 0; e < 8; e++) begin
                    ireg[b][e] <= 32'h0;
                    mreg[b][e] <= 32'h0;
                    lreg[b][e] <= 32'h0;
                    breg[b][e] <= 32'h0;
                end
            end
        end else if (ce) begin
            // Pointer update wins over a software write to the same index register
            if (wr_en && wr_bank == bank_sel[wr_idx[2]]) begin
                unique case (wr_file)
                    dagp_pkg::FILE_INDEX: ireg[wr_bank][wr_idx] <= wr_data;
                    dagp_pkg::FILE_MODIFY: mreg[wr_bank][wr_idx] <= wr_data;
                    dagp_pkg::FILE_LENGTH: lreg[wr_bank][wr_idx] <= wr_data;
                    dagp_pkg::FILE_BASE: breg[wr_bank][wr_idx] <= wr_data;
                endcase
            end
            if (updates) begin
                ireg[ib][op_ireg] <= next_i;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            addr <= 32'h0;
            addr_valid <= 1'b0;
            overflow <= 1'b0;
        end else if (ce) begin
            addr <= rev_here ? rev_addr : raw_addr;
            addr_valid <= is_access;
            overflow <= (op == dagp_pkg::DAGP_OP_POST) && past_end;
        end
    end
endmodule // dagp_gen
`default_nettype wire

// File: verilog/dagp_top.sv
// Data address generator pair: mode-control register, sticky overflow status and broadcast decode
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module dagp_top (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // First generator operation (data memory space)
    input wire dagp_pkg::dagp_op_t g1_op,
    input wire logic [2:0] g1_ireg,
    input wire logic [2:0] g1_mreg,
    input wire logic g1_use_imm,
    input wire logic [31:0] g1_imm,
    input wire logic g1_load,
    input wire logic g1_dreg_dest,
    // Second generator operation (program memory space)
    input wire dagp_pkg::dagp_op_t g2_op,
    input wire logic [2:0] g2_ireg,
    input wire logic [2:0] g2_mreg,
    input wire logic g2_use_imm,
    input wire logic [31:0] g2_imm,
    input wire logic g2_load,
    input wire logic g2_dreg_dest,
    // Address outputs
    output logic [31:0] data_memory_space_addr,
    output logic data_memory_space_valid,
    output logic [31:0] program_memory_space_addr,
    output logic program_memory_space_valid,
    // Load steering to the processing elements
    output logic primary_load_g1,
    output logic secondary_load_g1,
    output logic primary_load_g2,
    output logic secondary_load_g2,
    output logic dual_element_enable,
    output logic overflow_event
);
    // ------------------------------------------------------------
    // Mode-control and sticky status registers
    // ------------------------------------------------------------
    logic [31:0] core_mode_control;
    logic [1:0] sticky_status_register;
    logic [31:0] next_mode;
    logic [1:0] ovf;
    logic [31:0] g1_rd;
    logic [31:0] g2_rd;
    logic rd_hit;
    logic [31:0] next_rdata;

    wire logic mode_wr = reg_wr && (reg_addr == dagp_pkg::CORE_MODE_CONTROL_ADDR);
    wire logic sticky_wr = reg_wr && (reg_addr == dagp_pkg::STICKY_STATUS_ADDR);
    // File 3 is the base file unless bit 3 marks a special register
    wire logic reg_file_acc = !((reg_addr[7:6] == 2'h3) && reg_addr[3]);
    wire logic file_wr = reg_wr && reg_file_acc;
    wire logic file_g2 = reg_addr[5];
    assign next_mode = reg_wdata & dagp_pkg::CORE_MODE_CONTROL_MASK;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            core_mode_control <= dagp_pkg::CORE_MODE_CONTROL_RESET;
        end else if (ce && mode_wr) begin
            // Bank bits act on the next cycle's accesses
            core_mode_control <= next_mode;
        end
    end

    // ------------------------------------------------------------
    // Mode field decode
    // ------------------------------------------------------------
    wire logic wrap_mode_enable = core_mode_control[dagp_pkg::WRAP_MODE_ENABLE_BIT];
    wire logic broadcast_gen1_ptr1 = core_mode_control[dagp_pkg::BROADCAST_GEN1_PTR1_BIT];
    wire logic broadcast_gen2_ptr9 = core_mode_control[dagp_pkg::BROADCAST_GEN2_PTR9_BIT];
    wire logic alt_bank_gen2_low = core_mode_control[dagp_pkg::ALT_BANK_GEN2_LOW_BIT];
    wire logic alt_bank_gen2_high = core_mode_control[dagp_pkg::ALT_BANK_GEN2_HIGH_BIT];
    wire logic alt_bank_gen1_low = core_mode_control[dagp_pkg::ALT_BANK_GEN1_LOW_BIT];
    wire logic alt_bank_gen1_high = core_mode_control[dagp_pkg::ALT_BANK_GEN1_HIGH_BIT];
    wire logic bitrev_gen1_ptr0 = core_mode_control[dagp_pkg::BITREV_GEN1_PTR0_BIT];
    wire logic bitrev_gen2_ptr8 = core_mode_control[dagp_pkg::BITREV_GEN2_PTR8_BIT];
    assign dual_element_enable = core_mode_control[dagp_pkg::DUAL_ELEMENT_ENABLE_BIT];

    wire logic [1:0] g1_banks = {alt_bank_gen1_high, alt_bank_gen1_low};
    wire logic [1:0] g2_banks = {alt_bank_gen2_high, alt_bank_gen2_low};

    // ------------------------------------------------------------
    // Generators: first owns pointers 0-7, second owns 8-15
    // ------------------------------------------------------------
    dagp_gen #(.SECOND(1'b0)) u_first_address_generator (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .bank_sel(g1_banks),
        .wrap_en(wrap_mode_enable),
        .bitrev_en(bitrev_gen1_ptr0),
        .op(g1_op),
        .op_ireg(g1_ireg),
        .op_mreg(g1_mreg),
        .op_use_imm(g1_use_imm),
        .op_imm(g1_imm),
        .wr_en(file_wr && !file_g2),
        .wr_file(reg_addr[7:6]),
        .wr_bank(reg_addr[4]),
        .wr_idx(reg_addr[2:0]),
        .wr_data(reg_wdata),
        .rd_file(reg_addr[7:6]),
        .rd_bank(reg_addr[4]),
        .rd_idx(reg_addr[2:0]),
        .rd_data(g1_rd),
        .addr(data_memory_space_addr),
        .addr_valid(data_memory_space_valid),
        .overflow(ovf[0])
    );

    dagp_gen #(.SECOND(1'b1)) u_second_address_generator (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .bank_sel(g2_banks),
        .wrap_en(wrap_mode_enable),
        .bitrev_en(bitrev_gen2_ptr8),
        .op(g2_op),
        .op_ireg(g2_ireg),
        .op_mreg(g2_mreg),
        .op_use_imm(g2_use_imm),
        .op_imm(g2_imm),
        .wr_en(file_wr && file_g2),
        .wr_file(reg_addr[7:6]),
        .wr_bank(reg_addr[4]),
        .wr_idx(reg_addr[2:0]),
        .wr_data(reg_wdata),
        .rd_file(reg_addr[7:6]),
        .rd_bank(reg_addr[4]),
        .rd_idx(reg_addr[2:0]),
        .rd_data(g2_rd),
        .addr(program_memory_space_addr),
        .addr_valid(program_memory_space_valid),
        .overflow(ovf[1])
    );

    // ------------------------------------------------------------
    // Sticky overflow: hardware set wins over software clear
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sticky_status_register <= 2'h0;
        end else if (ce) begin
            sticky_status_register <= (sticky_wr ? (sticky_status_register & ~reg_wdata[1:0])
                                                 : sticky_status_register) | ovf;
        end
    end
    assign overflow_event = |ovf;

    // ------------------------------------------------------------
    // Broadcast load steering, independent of dual element mode
    // ------------------------------------------------------------
    wire logic g1_acc = (g1_op == dagp_pkg::DAGP_OP_POST) || (g1_op == dagp_pkg::DAGP_OP_PRE);
    wire logic g2_acc = (g2_op == dagp_pkg::DAGP_OP_POST) || (g2_op == dagp_pkg::DAGP_OP_PRE);
    wire logic g1_bc = broadcast_gen1_ptr1 && (g1_ireg == 3'd1);
    wire logic g2_bc = broadcast_gen2_ptr9 && (g2_ireg == 3'd1);
    logic [3:0] load_q;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            load_q <= 4'h0;
        end else if (ce) begin
            load_q[0] <= g1_acc && g1_load;
            load_q[1] <= g1_acc && g1_load && g1_dreg_dest && g1_bc;
            load_q[2] <= g2_acc && g2_load;
            load_q[3] <= g2_acc && g2_load && g2_dreg_dest && g2_bc;
        end
    end
    assign primary_load_g1 = load_q[0];
    assign secondary_load_g1 = load_q[1];
    assign primary_load_g2 = load_q[2];
    assign secondary_load_g2 = load_q[3];

    // ------------------------------------------------------------
    // Register read: data stand one cycle after the strobe
    // ------------------------------------------------------------
    assign rd_hit = reg_rd && ce;
    always_comb begin
        if (reg_addr == dagp_pkg::CORE_MODE_CONTROL_ADDR) begin
            next_rdata = core_mode_control;
        end else if (reg_addr == dagp_pkg::STICKY_STATUS_ADDR) begin
            next_rdata = {30'h0, sticky_status_register};
        end else if (reg_file_acc) begin
            next_rdata = file_g2 ? g2_rd : g1_rd;
        end else begin
            next_rdata = 32'h0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0;
        end else if (ce) begin
            reg_rdata <= rd_hit ? next_rdata : 32'h0;
        end
    end
endmodule // dagp_top
`default_nettype wire

// File: test/dagp_top_sva.sv
// Concurrent checks on the ports of the address generator pair
`timescale 1ns/100ps
`default_nettype none
module dagp_top_sva (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire dagp_pkg::dagp_op_t g1_op,
    input wire logic [2:0] g1_ireg,
    input wire logic g1_load,
    input wire logic g1_dreg_dest,
    input wire dagp_pkg::dagp_op_t g2_op,
    input wire logic g2_load,
    input wire logic data_memory_space_valid,
    input wire logic program_memory_space_valid,
    input wire logic primary_load_g1,
    input wire logic secondary_load_g1,
    input wire logic secondary_load_g2,
    input wire logic dual_element_enable,
    input wire logic overflow_event
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    wire logic acc1 = ce && g1_op inside {dagp_pkg::DAGP_OP_POST, dagp_pkg::DAGP_OP_PRE};
    wire logic mode_wr = ce && reg_wr && reg_addr == dagp_pkg::CORE_MODE_CONTROL_ADDR;
    property p_dm_access; acc1 |=> data_memory_space_valid; endproperty
    property p_dm_quiet; ce && g1_op == dagp_pkg::DAGP_OP_MODIFY |=> !data_memory_space_valid; endproperty
    property p_pm_pre; ce && g2_op == dagp_pkg::DAGP_OP_PRE |=> program_memory_space_valid; endproperty
    // A frozen cycle keeps the last pulse, so only enabled cycles must clear it
    property p_bc1_cause;
        ce && !(acc1 && g1_load && g1_dreg_dest && g1_ireg == 3'h1) |=> !secondary_load_g1;
    endproperty
    property p_bc1_pair; secondary_load_g1 |-> primary_load_g1 && data_memory_space_valid; endproperty
    property p_bc2_load; secondary_load_g2 |-> program_memory_space_valid && $past(g2_load); endproperty
    property p_pe_mode; mode_wr |=> dual_element_enable == $past(reg_wdata[21]); endproperty
    property p_pe_hold; !mode_wr |=> $stable(dual_element_enable); endproperty
    property p_ovf_post;
        overflow_event |-> $past(g1_op) == dagp_pkg::DAGP_OP_POST || $past(g2_op) == dagp_pkg::DAGP_OP_POST;
    endproperty
    a_dm_access: assert property (p_dm_access) else $error("data access missing");
    a_dm_quiet: assert property (p_dm_quiet) else $error("modify issued an access");
    a_pm_pre: assert property (p_pm_pre) else $error("pre-modify access missing");
    a_bc1_cause: assert property (p_bc1_cause) else $error("stray secondary load");
    a_bc1_pair: assert property (p_bc1_pair) else $error("secondary load without primary");
    a_bc2_load: assert property (p_bc2_load) else $error("secondary load without a load");
    a_pe_mode: assert property (p_pe_mode) else $error("dual element enable wrong");
    a_pe_hold: assert property (p_pe_hold) else $error("dual element enable moved");
    a_ovf_post: assert property (p_ovf_post) else $error("overflow without post-modify");
    c_ovf: cover property (overflow_event);
    c_bc1: cover property (secondary_load_g1);
    c_bc2: cover property (secondary_load_g2);
endmodule // dagp_top_sva
bind dagp_top dagp_top_sva chk_u (.mclk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .g1_op, .g1_ireg,
    .g1_load, .g1_dreg_dest, .g2_op, .g2_load, .data_memory_space_valid, .program_memory_space_valid,
    .primary_load_g1, .secondary_load_g1, .secondary_load_g2, .dual_element_enable, .overflow_event);
`default_nettype wire

// File: test/dagp_pe_model.sv
// Processing-element side model: counts writes into complementary registers
`timescale 1ns/100ps
`default_nettype none
module dagp_pe_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic secondary_load_g1,
    input wire logic secondary_load_g2,
    output var int sec_cnt
);
    // Both generators may broadcast in one cycle, so both pulses count
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sec_cnt <= 0;
        end else begin
            sec_cnt <= sec_cnt + int'(secondary_load_g1) + int'(secondary_load_g2);
        end
    end
endmodule // dagp_pe_model
`default_nettype wire

// File: test/test_data_address_generator_pair.sv
// Self-checking testbench for the address generator pair
`timescale 1ns/100ps
`default_nettype none
module test_data_address_generator_pair;
    localparam dagp_pkg::dagp_op_t POST = dagp_pkg::DAGP_OP_POST, PRE = dagp_pkg::DAGP_OP_PRE;
    localparam logic [7:0] MA = dagp_pkg::CORE_MODE_CONTROL_ADDR, SA = dagp_pkg::STICKY_STATUS_ADDR;
    localparam logic [1:0] FI = dagp_pkg::FILE_INDEX, FM = dagp_pkg::FILE_MODIFY, FL = dagp_pkg::FILE_LENGTH;
    logic mclk = 1'b0, rst_n = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, mode = 32'h0, iv, mv, v;
    dagp_pkg::dagp_op_t op [2] = '{POST, POST};
    logic [2:0] ireg [2] = '{3'h0, 3'h0}, mreg [2] = '{3'h0, 3'h0}, i, m;
    logic uimm [2] = '{1'b0, 1'b0}, ld [2] = '{1'b0, 1'b0}, dd [2] = '{1'b1, 1'b1};
    logic [31:0] imm [2] = '{32'h0, 32'h0}, addr [2];
    logic vld [2], pl [2], sl [2], dual_en, ovf;
    int err_total = 0, compares = 0, seed = 8, sec_cnt, g;
    dagp_pkg::dagp_op_t o;
    always #2 mclk = ~mclk;
    dagp_top dut_u (.mclk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .g1_op(op[0]), .g1_ireg(ireg[0]), .g1_mreg(mreg[0]), .g1_use_imm(uimm[0]), .g1_imm(imm[0]),
        .g1_load(ld[0]), .g1_dreg_dest(dd[0]), .g2_op(op[1]), .g2_ireg(ireg[1]), .g2_mreg(mreg[1]),
        .g2_use_imm(uimm[1]), .g2_imm(imm[1]), .g2_load(ld[1]), .g2_dreg_dest(dd[1]),
        .data_memory_space_addr(addr[0]), .data_memory_space_valid(vld[0]),
        .program_memory_space_addr(addr[1]), .program_memory_space_valid(vld[1]),
        .primary_load_g1(pl[0]), .secondary_load_g1(sl[0]), .primary_load_g2(pl[1]),
        .secondary_load_g2(sl[1]), .dual_element_enable(dual_en), .overflow_event(ovf));
    dagp_pe_model pe_u (.mclk, .rst_n, .secondary_load_g1(sl[0]), .secondary_load_g2(sl[1]), .sec_cnt);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // The port writes only the selected bank, so the bank bit follows the shadow mode
    function automatic logic [7:0] ra(input logic [1:0] f, input logic gn, input logic [2:0] e);
        logic b;
        b = gn ? mode[e[2] ? 5 : 6] : mode[e[2] ? 3 : 4];
        return {f, gn, b, 1'b0, e};
    endfunction
    function automatic logic [31:0] rev(input logic [31:0] x);
        logic [31:0] r;
        for (int k = 0; k < 32; k++) r[k] = x[31 - k];
        return r;
    endfunction
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", reg_rdata, exp);
    endtask
    task automatic setmode(input logic [31:0] d);
        mode = d;
        wr(MA, d);
    endtask
    task automatic go(input int gn, input dagp_pkg::dagp_op_t oc, input logic [2:0] ix, input logic [2:0] mx);
        op[gn] <= oc;
        ireg[gn] <= ix;
        mreg[gn] <= mx;
        @(posedge mclk);
        op[gn] <= dagp_pkg::DAGP_OP_NONE;
        #1;
    endtask
    task automatic print_verdict();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge mclk);
        err_total++;
        print_verdict();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        op <= '{dagp_pkg::DAGP_OP_NONE, dagp_pkg::DAGP_OP_NONE};
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        rchk(MA, 32'h0);
        rchk(SA, 32'h0);
        rchk(8'hFE, 32'h0);
        v = $random(seed);
        wr(MA, v);
        rchk(MA, v & dagp_pkg::CORE_MODE_CONTROL_MASK);
        chk("dual_element_enable", 32'(dual_en), 32'(v[21]));
        setmode(32'h0);
        for (int k = 0; k < 40; k++) begin
            g = k % 2;
            i = 3'($random(seed));
            m = 3'($random(seed));
            iv = $random(seed);
            mv = $random(seed);
            o = dagp_pkg::dagp_op_t'(2'(1 + k % 3));
            wr(ra(FI, g[0], i), iv);
            wr(ra(FM, g[0], m), mv);
            wr(ra(FL, g[0], m), ~mv);
            rchk(ra(FL, g[0], m), ~mv);
            imm[g] <= ~iv;
            uimm[g] <= k[2];
            go(g, o, i, m);
            if (k[2]) mv = ~iv;
            if (o != dagp_pkg::DAGP_OP_MODIFY) chk("mem_addr", addr[g], o == PRE ? iv + mv : iv);
            chk("mem_valid", 32'(vld[g]), 32'(o != dagp_pkg::DAGP_OP_MODIFY));
            rchk(ra(FI, g[0], i), o == PRE ? iv : iv + mv);
        end
        uimm <= '{1'b0, 1'b0};
        for (g = 0; g < 2; g++) begin
            setmode(g ? 32'h1 : 32'h2);
            iv = $random(seed);
            mv = $random(seed);
            wr(ra(FI, g[0], 3'h0), iv);
            wr(ra(FM, g[0], 3'h0), mv);
            go(g, POST, 3'h0, 3'h0);
            chk("rev_addr", addr[g], rev(iv));
            go(g, PRE, 3'h0, 3'h0);
            chk("rev_addr", addr[g], rev(iv + mv + mv));
            rchk(ra(FI, g[0], 3'h0), iv + mv);
        end
        setmode(32'h0100_0000);
        wr(ra(dagp_pkg::FILE_BASE, 1'b0, 3'h2), 32'h100);
        wr(ra(FL, 1'b0, 3'h2), 32'h10);
        wr(ra(FM, 1'b0, 3'h2), 32'h4);
        wr(ra(FI, 1'b0, 3'h2), 32'h10C);
        // A frozen cycle must neither issue the access nor move the pointer
        ce <= 1'b0;
        go(0, POST, 3'h2, 3'h2);
        chk("frozen_valid", 32'(vld[0]), 32'h0);
        ce <= 1'b1;
        go(0, POST, 3'h2, 3'h2);
        chk("overflow", 32'(ovf), 32'h1);
        go(0, POST, 3'h2, 3'h2);
        chk("overflow", 32'(ovf), 32'h0);
        chk("wrap_addr", addr[0], 32'h100);
        rchk(ra(FI, 1'b0, 3'h2), 32'h104);
        rchk(SA, 32'h1);
        wr(SA, 32'h1);
        rchk(SA, 32'h0);
        ld <= '{1'b1, 1'b1};
        for (int k = 0; k < 6; k++) begin
            setmode(k < 4 ? 32'h00C0_0000 | 32'(k[1]) << 21 : 32'h0);
            g = k % 2;
            dd[g] <= 1'b1;
            go(g, POST, 3'h1, 3'h0);
            chk("second_load", 32'(sl[g]), 32'(k < 4));
            chk("first_load", 32'(pl[g]), 32'h1);
            dd[g] <= 1'b0;
            go(g, POST, 3'h1, 3'h0);
            chk("second_load", 32'(sl[g]), 32'h0);
        end
        ld <= '{1'b0, 1'b0};
        setmode(32'h10);
        wr(ra(FI, 1'b0, 3'h0), 32'hB0);
        setmode(32'h0);
        wr(ra(FI, 1'b0, 3'h0), 32'hA0);
        setmode(32'h10);
        go(0, POST, 3'h0, 3'h0);
        chk("bank_addr", addr[0], 32'hB0);
        setmode(32'h0);
        rchk(ra(FI, 1'b0, 3'h0), 32'hA0);
        chk("broadcasts", 32'(sec_cnt), 32'h4);
        print_verdict();
    end
endmodule // test_data_address_generator_pair
`default_nettype wire
